// ===== inc/adsc_pkg.sv
// Constants, types and decode helpers of the actuator serial control block
// What this block does
// RULE_01: Sample serial input on rising clock, shift
// RULE_02: Commit frame only after exactly sixteen clocks
// RULE_03: No daisy chain; one select per device
// RULE_04: Select low drives summary; high floats output outside test mode
// RULE_05: First rising edge loads status; falling shifts
// RULE_06: First bit picks input and status register
// RULE_07: Bits one-eight drivers, nine-eleven monitor select
// RULE_08: Valid frame bit fifteen clears both status
// RULE_09: Summary bit is NOR of fault bits
// RULE_10: Over-current bit disables its driver unless its retry is enabled
// RULE_11: Thermal trip floats all drivers until cleared
// RULE_12: Status zero bit fifteen always reads one
// RULE_13: Bit fourteen masks open-load from summary
// RULE_14: Bit thirteen picks retry duty; warning forces low
// RULE_15: Bit twelve latches supply fault off until cleared
// RULE_16: Over/under voltage sets bit fourteen/thirteen
// RULE_17: Never both drivers of one half bridge
// RULE_18: Test mode output source chosen by double requests
// RULE_19: Test mode monitor source chosen by double requests
// RULE_20: Test entry indication; thresholds reduced fourfold
// RULE_21: Clock idle low, rising sample, LSB first
// RULE_22: Monitor select codes map to outputs one-five
// RULE_23: Bit counter cleared at select fall, saturates
package adsc_pkg;

  // Frame and counter sizes
  localparam int unsigned FRAME_BITS_DEF = 16;
  localparam int unsigned CNT_W          = 5;
  localparam int unsigned DRV_N          = 8;
  localparam int unsigned BRIDGE_N       = 3;

  // Control word zero field positions
  localparam int unsigned CW_SEL       = 0;
  localparam int unsigned CW_DRV_LO    = 1;
  localparam int unsigned CW_MON_LO    = 9;
  localparam int unsigned CW_SUP_LATCH = 12;
  localparam int unsigned CW_DUTY      = 13;
  localparam int unsigned CW_OL_MASK   = 14;
  localparam int unsigned CW_CLEAR     = 15;

  // Fault flags zero field positions
  localparam int unsigned FF_SUMMARY = 0;
  localparam int unsigned FF_OC_LO   = 1;
  localparam int unsigned FF_NRDY    = 10;
  localparam int unsigned FF_TWARN   = 11;
  localparam int unsigned FF_TRIP    = 12;
  localparam int unsigned FF_UV      = 13;
  localparam int unsigned FF_OV      = 14;
  localparam int unsigned FF_ONE     = 15;
  // Fault flags one: open-load bits
  localparam int unsigned FF_OL_LO   = 1;

  // Reset values
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;

  // Internal oscillator timing
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned OSC_HZ       = 2_000_000;
  localparam int unsigned OSC_HALF_CYC = CLK_HZ / (2 * OSC_HZ);
  localparam int unsigned OSC_W        = 5;

  typedef enum logic [1:0] {
    FR_IDLE   = 2'b01,
    FR_ACTIVE = 2'b10
  } adsc_frame_t;

  typedef enum logic [2:0] {
    DO_SUMMARY = 3'h0,
    DO_SERIAL  = 3'h1,
    DO_SCK     = 3'h2,
    DO_OSC     = 3'h3,
    DO_PWM     = 3'h4
  } adsc_do_src_t;

  typedef enum logic [3:0] {
    CM_NONE   = 4'h0,
    CM_OUT1   = 4'h1,
    CM_OUT2   = 4'h2,
    CM_OUT3   = 4'h3,
    CM_OUT4   = 4'h4,
    CM_OUT5   = 4'h5,
    CM_PROBE_A = 4'h6,
    CM_PROBE_B = 4'h7,
    CM_PROBE_C = 4'h8,
    CM_PROBE_D = 4'h9,
    CM_IREF   = 4'hA,
    CM_VBG    = 4'hB
  } adsc_cm_src_t;

  // Events reported by the power stage
  typedef struct packed {
    logic             over_voltage;
    logic             under_voltage;
    logic             thermal_trip;
    logic             temp_warn;
    logic             not_ready;
    logic [DRV_N-1:0] over_current;
    logic [DRV_N-1:0] open_load;
  } adsc_events_t;

  // Both drivers of half bridge k requested
  function automatic logic both_req(input logic [DRV_N-1:0] req,
                                    input int unsigned k);
    return req[2*k] & req[2*k+1];
  endfunction

endpackage

// ===== rtl/adsc_test_mux.sv
// Test-mode and monitor source selection
`timescale 1ns/1ps
module adsc_test_mux
  import adsc_pkg::*;
(
  // Mode and requests
  input  wire logic             test_mode,
  input  wire logic [DRV_N-1:0] drive_req,
  input  wire logic [2:0]       monitor_sel,
  // Selected sources
  output adsc_do_src_t          do_src,
  output adsc_cm_src_t          cm_src
);

  logic [BRIDGE_N-1:0] dbl;

  always_comb begin
    for (int unsigned k = 0; k < BRIDGE_N; k++) begin
      dbl[k] = both_req(drive_req, k);
    end
  end

  // RULE_18: output source decode
  always_comb begin
    do_src = DO_SUMMARY;
    if (test_mode) begin
      case (dbl)
        3'h1:    do_src = DO_SERIAL;
        3'h2:    do_src = DO_SCK;
        3'h3:    do_src = DO_OSC;
        3'h4:    do_src = DO_PWM;
        default: do_src = DO_SUMMARY;
      endcase
    end
  end

  always_comb begin
    cm_src = CM_NONE;
    if (test_mode) begin
      // RULE_19: monitor test source
      case (dbl)
        3'h1:    cm_src = CM_PROBE_A;
        3'h2:    cm_src = CM_PROBE_B;
        3'h3:    cm_src = CM_PROBE_C;
        3'h4:    cm_src = CM_PROBE_D;
        3'h6:    cm_src = CM_IREF;
        3'h7:    cm_src = CM_VBG;
        default: cm_src = CM_NONE;
      endcase
    end else begin
      // RULE_22: monitor select mapping
      case (monitor_sel)
        3'h0:    cm_src = CM_OUT1;
        3'h1:    cm_src = CM_OUT2;
        3'h2:    cm_src = CM_OUT3;
        3'h3:    cm_src = CM_OUT4;
        3'h4:    cm_src = CM_OUT5;
        default: cm_src = CM_NONE;
      endcase
    end
  end

endmodule

// ===== rtl/adsc_serial_ctrl.sv
// Serial slave, control and fault registers of the actuator driver
`timescale 1ns/1ps
module adsc_serial_ctrl
  import adsc_pkg::*;
#(
  parameter int unsigned FRAME_BITS = FRAME_BITS_DEF
)(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Serial link
  input  wire logic             chip_select_low,
  input  wire logic             sck,
  input  wire logic             serial_in,
  output logic                  serial_out,
  output logic                  serial_out_oe,
  // Power stage status
  input  adsc_events_t          events,
  input  wire logic [DRV_N-1:0] oc_retry_en,
  input  wire logic             pwm,
  input  wire logic             test_entry,
  // Driver and monitor control
  output logic [DRV_N-1:0]      drive_on,
  output logic [15:0]           control_word_one,
  output logic                  overcurrent_retry_duty,
  output logic                  oc_threshold_quarter,
  output adsc_cm_src_t          current_image_out,
  output logic                  fault_summary_bit
);

  if (FRAME_BITS < 2 || FRAME_BITS != 16) begin : g_check
    $error("FRAME_BITS must be 16");
  end

  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FRAME_BITS);
  localparam logic [CNT_W-1:0] CNT_SAT  = CNT_W'(FRAME_BITS + 1);
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_HALF_CYC - 1);

  // Edge detection
  logic sck_q;
  logic csn_q;
  logic sck_rise;
  logic sck_fall;
  logic csn_fall;
  logic csn_rise;

  // Frame state
  adsc_frame_t      frame;
  adsc_frame_t      next_frame;
  logic [CNT_W-1:0] bit_cnt;
  logic [CNT_W-1:0] next_bit_cnt;
  logic [15:0]      in_shift;
  logic [15:0]      next_in_shift;
  logic [15:0]      out_shift;
  logic [15:0]      next_out_shift;
  logic             out_loaded;
  logic             next_out_loaded;
  logic             reg_sel;
  logic             next_reg_sel;

  // Register file
  logic [15:0] control_word_zero;
  logic [15:0] next_control_word_zero;
  logic [15:0] next_control_word_one;
  logic [15:0] fault_flags_zero;
  logic [15:0] fault_flags_one;
  logic [15:0] flags0_q;
  logic [15:0] next_flags0_q;
  logic [15:0] flags1_q;
  logic [15:0] next_flags1_q;
  logic        commit;
  logic        clear_all;

  // Oscillator and outputs
  logic [OSC_W-1:0] osc_cnt;
  logic [OSC_W-1:0] next_osc_cnt;
  logic             osc;
  logic             next_osc;
  logic             next_serial_out;
  logic             next_serial_out_oe;
  logic [DRV_N-1:0] next_drive_on;
  logic             next_summary;
  logic             next_duty;
  logic             test_mode;
  logic             next_test_mode;
  adsc_do_src_t     do_src;
  adsc_cm_src_t     cm_src;

  assign sck_rise = sck & ~sck_q;
  assign sck_fall = ~sck & sck_q;
  assign csn_fall = ~chip_select_low & csn_q;
  assign csn_rise = chip_select_low & ~csn_q;

  // RULE_02: commit on exact count
  assign commit    = csn_rise && frame == FR_ACTIVE && bit_cnt == CNT_FULL;
  // RULE_08: clear both flag sets
  assign clear_all = commit && in_shift[CW_CLEAR];

  // Frame engine
  always_comb begin
    next_frame      = frame;
    next_bit_cnt    = bit_cnt;
    next_in_shift   = in_shift;
    next_out_shift  = out_shift;
    next_out_loaded = out_loaded;
    next_reg_sel    = reg_sel;
    unique case (frame)
      FR_IDLE: begin
        if (csn_fall) begin
          next_frame      = FR_ACTIVE;
          // RULE_23: counter cleared at start
          next_bit_cnt    = '0;
          next_out_loaded = 1'b0;
        end
      end
      FR_ACTIVE: begin
        if (csn_rise) begin
          next_frame = FR_IDLE;
        end else if (sck_rise) begin
          // RULE_01: LSB-first shift in
          // RULE_21: rising edge sampling
          next_in_shift = {serial_in, in_shift[15:1]};
          // RULE_23: saturating bit count
          if (bit_cnt != CNT_SAT) begin
            next_bit_cnt = bit_cnt + CNT_W'(1);
          end
          if (!out_loaded) begin
            // RULE_06: first bit selects
            next_reg_sel    = serial_in;
            // RULE_05: load selected status
            next_out_shift  = serial_in ? fault_flags_one : fault_flags_zero;
            next_out_loaded = 1'b1;
          end
        end else if (sck_fall && out_loaded) begin
          // RULE_05: shift on falling edge
          next_out_shift = {1'b0, out_shift[15:1]};
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      frame      <= FR_IDLE;
      bit_cnt    <= '0;
      in_shift   <= 16'h0000;
      out_shift  <= 16'h0000;
      out_loaded <= 1'b0;
      reg_sel    <= 1'b0;
      sck_q      <= 1'b0;
      csn_q      <= 1'b1;
    end else begin
      frame      <= next_frame;
      bit_cnt    <= next_bit_cnt;
      in_shift   <= next_in_shift;
      out_shift  <= next_out_shift;
      out_loaded <= next_out_loaded;
      reg_sel    <= next_reg_sel;
      sck_q      <= sck;
      csn_q      <= chip_select_low;
    end
  end

  // Control and fault registers
  always_comb begin
    next_control_word_zero = control_word_zero;
    next_control_word_one  = control_word_one;
    if (commit) begin
      // RULE_06: bit zero picks register
      if (reg_sel) begin
        next_control_word_one = in_shift;
      end else begin
        next_control_word_zero = in_shift;
      end
    end
    next_flags0_q = clear_all ? FLAGS_RESET : flags0_q;
    next_flags1_q = clear_all ? FLAGS_RESET : flags1_q;
    // RULE_16: supply faults set flags
    next_flags0_q[FF_OV] = next_flags0_q[FF_OV] | events.over_voltage;
    next_flags0_q[FF_UV] = next_flags0_q[FF_UV] | events.under_voltage;
    next_flags0_q[FF_TRIP] = next_flags0_q[FF_TRIP] | events.thermal_trip;
    next_flags0_q[FF_OC_LO +: DRV_N] =
      next_flags0_q[FF_OC_LO +: DRV_N] | events.over_current;
    next_flags1_q[FF_OL_LO +: DRV_N] =
      next_flags1_q[FF_OL_LO +: DRV_N] | events.open_load;
  end

  always_comb begin
    fault_flags_zero = flags0_q;
    fault_flags_one  = flags1_q;
    fault_flags_zero[FF_TWARN] = events.temp_warn;
    fault_flags_zero[FF_NRDY]  = events.not_ready;
    // RULE_09: summary NOR of fault bits
    // RULE_13: open-load mask
    next_summary = ~(|fault_flags_zero[14:1] |
                     (|fault_flags_one[14:1] &
                      ~control_word_zero[CW_OL_MASK]));
    fault_flags_zero[FF_SUMMARY] = fault_summary_bit;
    fault_flags_one[FF_SUMMARY]  = fault_summary_bit;
    // RULE_12: constant one marker
    fault_flags_zero[FF_ONE] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      control_word_zero <= CTRL_RESET;
      control_word_one  <= CTRL_RESET;
      flags0_q          <= FLAGS_RESET;
      flags1_q          <= FLAGS_RESET;
    end else begin
      control_word_zero <= next_control_word_zero;
      control_word_one  <= next_control_word_one;
      flags0_q          <= next_flags0_q;
      flags1_q          <= next_flags1_q;
    end
  end

  // Driver gating
  always_comb begin
    logic [DRV_N-1:0] req;
    logic             supply_off;
    // RULE_07: drive bits from word zero
    req = control_word_zero[CW_DRV_LO +: DRV_N];
    // RULE_15: latched or automatic recovery
    supply_off = events.over_voltage | events.under_voltage |
                 (control_word_zero[CW_SUP_LATCH] &
                  (flags0_q[FF_OV] | flags0_q[FF_UV]));
    // RULE_10: over-current blocks driver without retry enable
    req = req & ~(flags0_q[FF_OC_LO +: DRV_N] & ~oc_retry_en);
    next_drive_on = req;
    // RULE_17: cross-conduction lockout
    for (int unsigned k = 0; k < BRIDGE_N; k++) begin
      if (both_req(req, k)) begin
        next_drive_on[2*k]   = 1'b0;
        next_drive_on[2*k+1] = 1'b0;
      end
    end
    // RULE_11: thermal trip floats all
    // RULE_16: supply fault deactivates
    if (flags0_q[FF_TRIP] || supply_off) begin
      next_drive_on = '0;
    end
    // RULE_14: warning forces low duty
    next_duty = control_word_zero[CW_DUTY] & ~events.temp_warn;
    // RULE_20: test entry indication
    next_test_mode = test_entry;
  end

  // Internal oscillator divider
  always_comb begin
    next_osc_cnt = osc_cnt + OSC_W'(1);
    next_osc     = osc;
    if (osc_cnt == OSC_LAST) begin
      next_osc_cnt = '0;
      next_osc     = ~osc;
    end
  end

  adsc_test_mux i_adsc_test_mux (
    .test_mode   (test_mode),
    .drive_req   (control_word_zero[CW_DRV_LO +: DRV_N]),
    .monitor_sel (control_word_zero[CW_MON_LO +: 3]),
    .do_src      (do_src),
    .cm_src      (cm_src)
  );

  // Serial output source
  always_comb begin
    // RULE_04: enable while selected
    next_serial_out_oe = ~chip_select_low | test_mode;
    next_serial_out    = out_loaded ? out_shift[0] : next_summary;
    if (test_mode) begin
      // RULE_18: test sources on output
      unique case (do_src)
        DO_SUMMARY: next_serial_out = next_summary;
        DO_SERIAL:  next_serial_out = serial_in;
        DO_SCK:     next_serial_out = sck;
        DO_OSC:     next_serial_out = osc;
        DO_PWM:     next_serial_out = pwm;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      osc_cnt                <= '0;
      osc                    <= 1'b0;
      serial_out             <= 1'b0;
      serial_out_oe          <= 1'b0;
      drive_on               <= '0;
      fault_summary_bit      <= 1'b1;
      overcurrent_retry_duty <= 1'b0;
      oc_threshold_quarter   <= 1'b0;
      test_mode              <= 1'b0;
      current_image_out      <= CM_NONE;
    end else begin
      osc_cnt                <= next_osc_cnt;
      osc                    <= next_osc;
      serial_out             <= next_serial_out;
      serial_out_oe          <= next_serial_out_oe;
      drive_on               <= next_drive_on;
      fault_summary_bit      <= next_summary;
      overcurrent_retry_duty <= next_duty;
      // RULE_20: reduced thresholds in test
      oc_threshold_quarter   <= next_test_mode;
      test_mode              <= next_test_mode;
      current_image_out      <= cm_src;
    end
  end

endmodule

// ===== verification/adsc_serial_ctrl_asserts.sv
// Assertion checker for the actuator serial control block
`timescale 1ns/1ps
module adsc_serial_ctrl_asserts
  import adsc_pkg::*;
#(
  parameter int unsigned FRAME_BITS = FRAME_BITS_DEF
)(
  // Clock and reset
  input wire logic             clk,
  input wire logic             reset,
  // Serial link
  input wire logic             chip_select_low,
  input wire logic             sck,
  input wire logic             serial_in,
  input wire logic             serial_out,
  input wire logic             serial_out_oe,
  // Power stage status
  input wire adsc_events_t     events,
  input wire logic [DRV_N-1:0] oc_retry_en,
  input wire logic             pwm,
  input wire logic             test_entry,
  // Driver and monitor control
  input wire logic [DRV_N-1:0] drive_on,
  input wire logic [15:0]      control_word_one,
  input wire logic             overcurrent_retry_duty,
  input wire logic             oc_threshold_quarter,
  input wire adsc_cm_src_t     current_image_out,
  input wire logic             fault_summary_bit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_oe_on; !chip_select_low[*3] |=> serial_out_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("output off in frame");
  property p_oe_off;
    (chip_select_low && !test_entry)[*3] |=> !serial_out_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven idle");
  property p_poll;
    ($fell(chip_select_low) && !test_entry) ##1
      (!chip_select_low && !sck && !test_entry &&
       $stable(fault_summary_bit))[*3]
      |=> serial_out == fault_summary_bit;
  endproperty
  a_poll: assert property (p_poll) else $error("poll bit wrong");
  property p_bridge; !(|(drive_on[5:0] & (drive_on[5:0] >> 1) & 6'h15));
  endproperty
  a_bridge: assert property (p_bridge) else $error("bridge both on");
  property p_trip;
    $rose(events.thermal_trip) |-> ##3 (drive_on == 8'h00)[*4];
  endproperty
  a_trip: assert property (p_trip) else $error("driver on in trip");
  property p_ov;
    $rose(events.over_voltage) |-> ##3 drive_on == 8'h00 && !fault_summary_bit;
  endproperty
  a_ov: assert property (p_ov) else $error("supply fault ignored");
  property p_oc;
    events.over_current[0] && !oc_retry_en[0] |-> ##3 !drive_on[0];
  endproperty
  a_oc: assert property (p_oc) else $error("over-current ignored");
  property p_warn; events.temp_warn[*3] |=> !overcurrent_retry_duty;
  endproperty
  a_warn: assert property (p_warn) else $error("duty high in warning");
  property p_test;
    test_entry[*3] |=> oc_threshold_quarter && serial_out_oe;
  endproperty
  a_test: assert property (p_test) else $error("test mode not entered");

  c_frame: cover property ($rose(chip_select_low));
  c_trip: cover property ($rose(events.thermal_trip));
  c_test: cover property ($rose(test_entry));
endmodule

bind adsc_serial_ctrl adsc_serial_ctrl_asserts #(.FRAME_BITS(FRAME_BITS))
  i_adsc_serial_ctrl_asserts (
  .clk(clk), .reset(reset), .chip_select_low(chip_select_low), .sck(sck),
  .serial_in(serial_in), .serial_out(serial_out),
  .serial_out_oe(serial_out_oe), .events(events),
  .oc_retry_en(oc_retry_en), .pwm(pwm), .test_entry(test_entry),
  .drive_on(drive_on), .control_word_one(control_word_one),
  .overcurrent_retry_duty(overcurrent_retry_duty),
  .oc_threshold_quarter(oc_threshold_quarter),
  .current_image_out(current_image_out),
  .fault_summary_bit(fault_summary_bit));

// ===== verification/adsc_spi_master.sv
// Serial master model sending frames to the control block
`timescale 1ns/1ps
module adsc_spi_master (
  // Clock
  input  wire logic clk,
  // Serial link
  output logic      chip_select_low,
  output logic      sck,
  output logic      serial_in,
  input  wire logic serial_out
);
  logic [15:0] rx_word;
  logic        poll_bit;
  event        frame_done;

  initial begin
    chip_select_low = 1'b1;
    sck = 1'b0;
    serial_in = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic xfer(input logic [15:0] tx, input int n);
    chip_select_low = 1'b0;
    wait_clk(4);
    poll_bit = serial_out;
    for (int i = 0; i < n; i++) begin
      serial_in = tx[i%16];
      wait_clk(4);
      sck = 1'b1;
      wait_clk(4);
      if (i < 16) rx_word[i] = serial_out;
      sck = 1'b0;
    end
    wait_clk(4);
    chip_select_low = 1'b1;
    serial_in = ~serial_in;
    wait_clk(4);
    if (n == 16) ->frame_done;
  endtask
endmodule

// ===== verification/tb_actuator_driver_serial_control.sv
// Self-checking testbench of the actuator serial control block
`timescale 1ns/1ps
module tb_actuator_driver_serial_control
  import adsc_pkg::*;
();
  logic             clk, reset, test_entry, pwm, chip_select_low, sck;
  logic             serial_in, serial_out, serial_out_oe, duty, quarter;
  logic             summary;
  adsc_events_t     events;
  logic [DRV_N-1:0] oc_retry_en, drive_on;
  logic [15:0]      control_word_one;
  adsc_cm_src_t     cm;
  logic [15:0]      exp_q[$];
  int               n_fail, comparisons, cycles;
  adsc_cm_src_t     cm_tab[8] = '{CM_NONE, CM_PROBE_A, CM_PROBE_B,
                                  CM_PROBE_C, CM_PROBE_D, CM_NONE, CM_IREF,
                                  CM_VBG};

  adsc_serial_ctrl i_adsc_serial_ctrl (
    .clk(clk), .reset(reset), .chip_select_low(chip_select_low),
    .sck(sck), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .events(events),
    .oc_retry_en(oc_retry_en), .pwm(pwm), .test_entry(test_entry),
    .drive_on(drive_on), .control_word_one(control_word_one),
    .overcurrent_retry_duty(duty), .oc_threshold_quarter(quarter),
    .current_image_out(cm), .fault_summary_bit(summary));
  adsc_spi_master i_adsc_spi_master (
    .clk(clk), .chip_select_low(chip_select_low), .sck(sck),
    .serial_in(serial_in), .serial_out(serial_out));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] tx, input logic [15:0] rx_exp);
    exp_q.push_back(rx_exp);
    i_adsc_spi_master.xfer(tx, 16);
  endtask

  function automatic logic [7:0] drv_exp(input logic [7:0] r);
    for (int k = 0; k < 3; k++)
      if (r[2*k] && r[2*k+1]) r[2*k+:2] = 2'b00;
    return r;
  endfunction

  initial begin
    logic [15:0] rx;
    forever begin
      @(i_adsc_spi_master.frame_done);
      if (exp_q.size() > 0) begin
        rx = exp_q.pop_front();
        check("rx_word", i_adsc_spi_master.rx_word, rx);
      end
    end
  end

  initial begin
    logic [7:0]  r;
    logic [15:0] w;
    reset = 1'b1;
    test_entry = 1'b0;
    pwm = 1'b0;
    events = '0;
    oc_retry_en = '0;
    void'($urandom(98));
    step(8);
    reset = 1'b0;
    check("oe", serial_out_oe, 1'b0);
    check("summary", summary, 1'b1);
    for (int s = 0; s < 8; s++) begin
      r = 8'($urandom);
      wr({4'h0, 3'(s), r, 1'b0}, 16'h8001);
      check("drive_on", drive_on, drv_exp(r));
      w = (s < 5) ? 16'(CM_OUT1 + s) : 16'(CM_NONE);
      check("monitor", cm, w);
    end
    wr(16'h000A, 16'h8001);
    i_adsc_spi_master.xfer(16'h0000, 15);
    i_adsc_spi_master.xfer(16'h0000, 17);
    check("drive_on", drive_on, 8'h05);
    w = (16'($urandom) & 16'h7FFF) | 16'h0001;
    wr(w, 16'h0001);
    check("word_one", control_word_one, w);
    check("drive_on", drive_on, 8'h05);
    $display("test frames done");
    events.thermal_trip = 1'b1;
    step(3);
    events.thermal_trip = 1'b0;
    step(2);
    check("drive_on", drive_on, 8'h00);
    check("summary", summary, 1'b0);
    i_adsc_spi_master.xfer(16'h0000, 0);
    check("poll", i_adsc_spi_master.poll_bit, 1'b0);
    wr(16'h000A, 16'h9000);
    check("drive_on", drive_on, 8'h00);
    wr(16'h800A, 16'h9000);
    check("drive_on", drive_on, 8'h05);
    events.open_load[2] = 1'b1;
    step(3);
    events.open_load[2] = 1'b0;
    step(2);
    wr(16'h0001, 16'h0008);
    wr(16'h400A, 16'h8000);
    check("summary", summary, 1'b1);
    wr(16'h800A, 16'h8001);
    $display("test faults done");
    wr(16'h100A, 16'h8001);
    events.over_voltage = 1'b1;
    step(3);
    check("drive_on", drive_on, 8'h00);
    events.over_voltage = 1'b0;
    step(3);
    check("drive_on", drive_on, 8'h00);
    wr(16'h800A, 16'hC000);
    check("drive_on", drive_on, 8'h05);
    events.under_voltage = 1'b1;
    step(3);
    events.under_voltage = 1'b0;
    step(3);
    check("drive_on", drive_on, 8'h05);
    wr(16'h800A, 16'hA000);
    events.over_current[0] = 1'b1;
    step(3);
    events.over_current[0] = 1'b0;
    step(3);
    check("drive_on", drive_on, 8'h04);
    oc_retry_en[0] = 1'b1;
    step(2);
    check("drive_on", drive_on, 8'h05);
    oc_retry_en[0] = 1'b0;
    wr(16'h800A, 16'h8002);
    check("drive_on", drive_on, 8'h05);
    wr(16'h200A, 16'h8001);
    check("duty", duty, 1'b1);
    events.temp_warn = 1'b1;
    step(4);
    check("duty", duty, 1'b0);
    events.temp_warn = 1'b0;
    step(3);
    check("duty", duty, 1'b1);
    $display("test supply done");
    test_entry = 1'b1;
    step(4);
    check("quarter", quarter, 1'b1);
    check("oe", serial_out_oe, 1'b1);
    for (int m = 0; m < 8; m++) begin
      i_adsc_spi_master.xfer({9'h000, {2{m[2]}}, {2{m[1]}}, {2{m[0]}},
                              1'b0}, 16);
      pwm = 1'($urandom);
      step(3);
      check("monitor", cm, cm_tab[m]);
      check("drive_on", drive_on, 8'h00);
      case (m)
        0: check("dout", serial_out, 1'b1);
        1: check("dout", serial_out, serial_in);
        2: check("dout", serial_out, sck);
        3: begin
          w[0] = serial_out;
          step(25);
          check("dout", serial_out, 1'(~w[0]));
        end
        4: check("dout", serial_out, pwm);
        default: ;
      endcase
    end
    test_entry = 1'b0;
    step(4);
    check("oe", serial_out_oe, 1'b0);
    $display("test mode done");
    final_report();
  end
endmodule
